/* rtl/odt_params.svh */
// offsets, reset values, command codes and counts for the termination controller
`ifndef ODT_PARAMS_SVH
`define ODT_PARAMS_SVH

`define ODT_ADR_CTRL 8'h00
`define ODT_ADR_STATUS 8'h04
`define ODT_ADR_CFG 8'h08

`define ODT_CTRL_EN_BIT 0
`define ODT_CTRL_RESET 1'b0

`define ODT_CMD_CONFIGURE 8'hE2
`define ODT_CMD_HARD_RESET 8'hFD
`define ODT_CMD_RESET_A 8'hFA
`define ODT_CMD_RESET_B 8'hFC
`define ODT_CMD_RESET_C 8'hFF

`define ODT_CFG_BYTES 3'h4
`define ODT_CFG_RESET 8'h00
`define ODT_SELF_RTT 3'h2

`define ODT_PIN_W 14
`define ODT_PIN_IDLE 14'h0039
`define ODT_PIN_CE_N 0
`define ODT_PIN_CLE 1
`define ODT_PIN_ALE 2
`define ODT_PIN_WE_N 3
`define ODT_PIN_RE_N 4
`define ODT_PIN_DQS 5
`define ODT_PIN_DQ 6+:8

`endif

/* rtl/odt_pkg.sv */
// types and decode helpers for the termination controller
package odt_pkg;

    typedef logic [2:0] rtt_code_t;

    typedef enum logic [1:0] {
        LUN_SELF,
        LUN_IDLE,
        LUN_SELECTED,
        LUN_SNIFF
    } lun_state_t;

    // nibble code: 0 off, 1 150, 2 100, 3 75, 4 50 ohm; anything else off
    function automatic rtt_code_t rtt_decode(input logic [3:0] nib);
        rtt_decode = (nib <= 4'h4) ? nib[2:0] : 3'h0;
    endfunction

endpackage

/* rtl/odt_cfg_if.sv */
// carrier between the controller and its configuration store
`timescale 1ns/10ps
`default_nettype none
interface odt_cfg_if;
    logic load;
    logic clear;
    logic [1:0] idx;
    logic [7:0] wbyte;
    logic [7:0] volume_mask_byte;
    logic [7:0] volume_mask_high_byte;
    logic [7:0] data_line_strength_byte;
    logic [7:0] read_enable_strength_byte;

    modport ctl (output load, clear, idx, wbyte,
                 input volume_mask_byte, volume_mask_high_byte,
                 data_line_strength_byte, read_enable_strength_byte);
    modport store (input load, clear, idx, wbyte,
                   output volume_mask_byte, volume_mask_high_byte,
                   data_line_strength_byte, read_enable_strength_byte);
endinterface
`default_nettype wire

/* rtl/odt_pin_sync.sv */
// three-stage synchroniser with agreement filter for the bus pins
`timescale 1ns/10ps
`default_nettype none
`include "odt_params.svh"
module odt_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`ODT_PIN_W-1:0] pin_i,
    output logic [`ODT_PIN_W-1:0] pin_o
);
    logic [`ODT_PIN_W-1:0] s1_r;
    logic [`ODT_PIN_W-1:0] s2_r;
    logic [`ODT_PIN_W-1:0] s3_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= `ODT_PIN_IDLE;
            s2_r <= `ODT_PIN_IDLE;
            s3_r <= `ODT_PIN_IDLE;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit moves only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= `ODT_PIN_IDLE;
        end else begin
            pin_o <= (s2_r & s3_r) | (pin_o & (s2_r ^ s3_r));
        end
    end
endmodule // odt_pin_sync
`default_nettype wire

/* rtl/odt_cfg_store.sv */
// per-LUN termination matrix bytes
`timescale 1ns/10ps
`default_nettype none
`include "odt_params.svh"
module odt_cfg_store (
    input wire logic clk_i,
    input wire logic rst_i,
    odt_cfg_if.store cfg
);
    logic [7:0] byte_r [4];

    always_ff @(posedge clk_i) begin
        if (rst_i || cfg.clear) begin
            for (int i = 0; i < 4; i++) begin
                byte_r[i] <= `ODT_CFG_RESET;
            end
        end else if (cfg.load) begin
            byte_r[cfg.idx] <= cfg.wbyte;
        end
    end

    assign cfg.volume_mask_byte = byte_r[0];
    assign cfg.volume_mask_high_byte = byte_r[1];
    assign cfg.data_line_strength_byte = byte_r[2];
    assign cfg.read_enable_strength_byte = byte_r[3];
endmodule // odt_cfg_store
`default_nettype wire

/* rtl/odt_termination_control.sv */
// on-die termination control for one LUN of a flash target
// Overview of operation
// - in self mode only the executing LUN switches termination on.
// - configure command seen on the bus moves the target to matrix mode.
// - self mode terminates strobe and data lines during data input.
// - self mode terminates read enable during data output.
// - selected volume gives Selected, configured other volume Sniff, else idle.
// - a terminator serves its own selected volume or another selected volume.
// - executing and non-executing LUNs on selected volume may terminate.
// - Selected LUN uses internal burst state, not bus lines alone.
// - Sniff LUN watches ALE, CLE, DQS and read enable for on and off.
// - each LUN keeps separate output and input strengths.
// - mask 0Ch, strength 40h gives 50 ohm output for volumes 2, 3.
// - mask 01h, bytes 02h 03h: volume 0 input 100 ohm, RE 75.
// - masks 02h, 04h, 08h select volumes 1, 2, 3.
// - mask 03h, strength 40h gives 50 ohm output for volumes 0, 1.
// - all-zero configuration never terminates.
// - settings survive ordinary resets, cleared by hard reset for this LUN.
// - enable by feature alone gives self termination.
// - termination holds through a paused burst.
`timescale 1ns/10ps
`default_nettype none
`include "odt_params.svh"
module odt_termination_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic ce_n_i,
    input wire logic cle_i,
    input wire logic ale_i,
    input wire logic we_n_i,
    input wire logic re_n_i,
    input wire logic dqs_i,
    input wire logic [7:0] dq_i,
    input wire logic lun_exec_i,
    input wire logic lun_addressed_i,
    input wire logic [3:0] own_vol_i,
    input wire logic [3:0] sel_vol_i,
    input wire logic data_in_burst_i,
    input wire logic data_out_burst_i,
    output logic dq_odt_en_o,
    output logic re_odt_en_o,
    output odt_pkg::rtt_code_t dq_rtt_o,
    output odt_pkg::rtt_code_t re_rtt_o
);
    import odt_pkg::*;

    logic [`ODT_PIN_W-1:0] pin;
    logic [`ODT_PIN_W-1:0] pin_prev_r;
    logic odt_en_r;
    logic matrix_r;
    logic [2:0] param_cnt_r;
    logic sniff_in_r;
    logic sniff_out_r;
    lun_state_t lun_state_r;
    lun_state_t lun_state_nxt;
    logic dq_on_nxt;
    logic re_on_nxt;
    rtt_code_t dq_code_nxt;
    rtt_code_t re_code_nxt;
    logic [15:0] vol_mask;
    rtt_code_t out_code;
    rtt_code_t in_code;
    rtt_code_t re_code;
    logic we_rise;
    logic dqs_rise;
    logic dqs_fall;
    logic re_fall;
    logic cmd_cycle;
    logic data_cycle;
    logic [7:0] cmd_byte;
    logic bus_hit;
    logic ack_r;

    odt_cfg_if cfg ();

    odt_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({dq_i, dqs_i, re_n_i, we_n_i, ale_i, cle_i, ce_n_i}),
        .pin_o(pin)
    );

    odt_cfg_store u_cfg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg(cfg)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_r <= `ODT_PIN_IDLE;
        end else begin
            pin_prev_r <= pin;
        end
    end

    assign we_rise = pin[`ODT_PIN_WE_N] & ~pin_prev_r[`ODT_PIN_WE_N];
    assign dqs_rise = pin[`ODT_PIN_DQS] & ~pin_prev_r[`ODT_PIN_DQS];
    assign dqs_fall = ~pin[`ODT_PIN_DQS] & pin_prev_r[`ODT_PIN_DQS];
    assign re_fall = ~pin[`ODT_PIN_RE_N] & pin_prev_r[`ODT_PIN_RE_N];
    assign cmd_byte = pin[`ODT_PIN_DQ];
    assign cmd_cycle = we_rise & ~pin[`ODT_PIN_CE_N] & pin[`ODT_PIN_CLE]
                       & ~pin[`ODT_PIN_ALE] & pin[`ODT_PIN_RE_N];
    assign data_cycle = dqs_rise & ~pin[`ODT_PIN_CE_N] & ~pin[`ODT_PIN_CLE]
                        & ~pin[`ODT_PIN_ALE];

    // every LUN sees the configure command, so all of them leave self mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            matrix_r <= 1'b0;
        end else if (cmd_cycle && cmd_byte == `ODT_CMD_CONFIGURE) begin
            matrix_r <= 1'b1;
        end
    end

    // parameter bytes arrive on strobe edges after the command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            param_cnt_r <= 3'h0;
        end else if (cmd_cycle) begin
            param_cnt_r <= (cmd_byte == `ODT_CMD_CONFIGURE) ? `ODT_CFG_BYTES : 3'h0;
        end else if (data_cycle && param_cnt_r != 3'h0) begin
            param_cnt_r <= param_cnt_r - 3'h1;
        end
    end

    always_comb begin
        cfg.load = data_cycle && param_cnt_r != 3'h0 && lun_addressed_i;
        cfg.idx = 2'(`ODT_CFG_BYTES - param_cnt_r);
        cfg.wbyte = cmd_byte;
        cfg.clear = 1'b0;
        if (cmd_cycle && lun_addressed_i) begin
            case (cmd_byte)
                `ODT_CMD_HARD_RESET: cfg.clear = 1'b1;
                `ODT_CMD_RESET_A,
                `ODT_CMD_RESET_B,
                `ODT_CMD_RESET_C: cfg.clear = 1'b0;
                default: cfg.clear = 1'b0;
            endcase
        end
    end

    assign vol_mask = {cfg.volume_mask_high_byte, cfg.volume_mask_byte};
    assign out_code = rtt_decode(cfg.data_line_strength_byte[7:4]);
    assign in_code = rtt_decode(cfg.data_line_strength_byte[3:0]);
    assign re_code = rtt_decode(cfg.read_enable_strength_byte[3:0]);

    // bus-only burst tracking for a LUN on an unselected volume;
    // a pause leaves the flags set, only command, address or deselect end them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sniff_in_r <= 1'b0;
            sniff_out_r <= 1'b0;
        end else if (pin[`ODT_PIN_CE_N] || pin[`ODT_PIN_CLE] || pin[`ODT_PIN_ALE]) begin
            sniff_in_r <= 1'b0;
            sniff_out_r <= 1'b0;
        end else begin
            if (dqs_fall && pin[`ODT_PIN_RE_N]) begin
                sniff_in_r <= 1'b1;
            end
            if (re_fall) begin
                sniff_out_r <= 1'b1;
            end
        end
    end

    always_comb begin
        if (!matrix_r) begin
            lun_state_nxt = LUN_SELF;
        end else if (sel_vol_i == own_vol_i) begin
            lun_state_nxt = LUN_SELECTED;
        end else if (vol_mask[sel_vol_i]) begin
            lun_state_nxt = LUN_SNIFF;
        end else begin
            lun_state_nxt = LUN_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lun_state_r <= LUN_SELF;
        end else begin
            lun_state_r <= lun_state_nxt;
        end
    end

    always_comb begin
        dq_on_nxt = 1'b0;
        re_on_nxt = 1'b0;
        dq_code_nxt = 3'h0;
        re_code_nxt = 3'h0;
        case (lun_state_r)
            LUN_SELF: begin
                if (odt_en_r && lun_exec_i) begin
                    if (data_in_burst_i) begin
                        dq_on_nxt = 1'b1;
                        dq_code_nxt = `ODT_SELF_RTT;
                    end
                    if (data_out_burst_i) begin
                        re_on_nxt = 1'b1;
                        re_code_nxt = `ODT_SELF_RTT;
                    end
                end
            end
            LUN_SELECTED: begin
                // internal burst state drives this, not the pins
                if (vol_mask[own_vol_i]) begin
                    if (data_in_burst_i && in_code != 3'h0) begin
                        dq_on_nxt = 1'b1;
                        dq_code_nxt = in_code;
                    end else if (data_out_burst_i && !lun_exec_i && out_code != 3'h0) begin
                        dq_on_nxt = 1'b1;
                        dq_code_nxt = out_code;
                    end
                    if (data_out_burst_i && re_code != 3'h0) begin
                        re_on_nxt = 1'b1;
                        re_code_nxt = re_code;
                    end
                end
            end
            LUN_SNIFF: begin
                // non-target: mask bit for the selected volume already checked
                if (sniff_in_r && in_code != 3'h0) begin
                    dq_on_nxt = 1'b1;
                    dq_code_nxt = in_code;
                end else if (sniff_out_r && out_code != 3'h0) begin
                    dq_on_nxt = 1'b1;
                    dq_code_nxt = out_code;
                end
                if (sniff_out_r && re_code != 3'h0) begin
                    re_on_nxt = 1'b1;
                    re_code_nxt = re_code;
                end
            end
            default: begin
                dq_on_nxt = 1'b0;
                re_on_nxt = 1'b0;
            end
        endcase
    end

    // a paused burst keeps the burst inputs and sniff flags up, so this holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_odt_en_o <= 1'b0;
            re_odt_en_o <= 1'b0;
            dq_rtt_o <= 3'h0;
            re_rtt_o <= 3'h0;
        end else begin
            dq_odt_en_o <= dq_on_nxt;
            re_odt_en_o <= re_on_nxt;
            dq_rtt_o <= dq_code_nxt;
            re_rtt_o <= re_code_nxt;
        end
    end

    // wishbone classic slave, one wait state
    assign bus_hit = cyc_i & stb_i & ~ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_hit;
        end
    end

    assign ack_o = ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odt_en_r <= `ODT_CTRL_RESET;
        end else if (bus_hit && we_i && sel_i[0] && adr_i == `ODT_ADR_CTRL) begin
            odt_en_r <= dat_i[`ODT_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (bus_hit && !we_i) begin
            case (adr_i)
                `ODT_ADR_CTRL: dat_o <= {31'h0, odt_en_r};
                `ODT_ADR_STATUS: dat_o <= {21'h0, re_rtt_o, dq_rtt_o, re_odt_en_o,
                                          dq_odt_en_o, lun_state_r, matrix_r};
                `ODT_ADR_CFG: dat_o <= {cfg.read_enable_strength_byte, cfg.data_line_strength_byte,
                                       cfg.volume_mask_high_byte, cfg.volume_mask_byte};
                default: dat_o <= 32'h0;
            endcase
        end
    end
endmodule // odt_termination_control
`default_nettype wire

/* tb/odt_termination_control_checker.sv */
// bus and termination assertions for the termination controller
`timescale 1ns/10ps
`default_nettype none
module odt_termination_control_checker
    import odt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [3:0] own_vol_i,
    input wire logic [3:0] sel_vol_i,
    input wire logic data_in_burst_i,
    input wire logic data_out_burst_i,
    input wire logic dq_odt_en_o,
    input wire logic re_odt_en_o,
    input wire odt_pkg::rtt_code_t dq_rtt_o,
    input wire odt_pkg::rtt_code_t re_rtt_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence taken_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // own volume selected and no burst: neither self nor selected may terminate
    sequence quiet_s;
        own_vol_i == sel_vol_i && !data_in_burst_i && !data_out_burst_i;
    endsequence
    a_ack_answer: assert property (taken_s |=> ack_o) else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 8'h08 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_read_hold: assert property (!(ack_o && !we_i) |-> $stable(dat_o)) else $error("read data moved");
    // reset must win even though the default disable is reset itself
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !dq_odt_en_o && !re_odt_en_o)
        else $error("outputs active after reset");
    a_code_range: assert property (dq_rtt_o <= 3'h4 && re_rtt_o <= 3'h4)
        else $error("strength code out of range");
    a_quiet_off: assert property (quiet_s [*3] |=> !dq_odt_en_o && !re_odt_en_o)
        else $error("termination without burst");
endmodule // odt_termination_control_checker
bind odt_termination_control odt_termination_control_checker i_chk (.clk_i, .rst_i, .adr_i, .dat_o, .we_i,
    .cyc_i, .stb_i, .ack_o, .own_vol_i, .sel_vol_i, .data_in_burst_i, .data_out_burst_i, .dq_odt_en_o,
    .re_odt_en_o, .dq_rtt_o, .re_rtt_o);
`default_nettype wire

/* tb/odt_host_model.sv */
// host flash controller driving the bus pins
`timescale 1ns/10ps
`default_nettype none
module odt_host_model #(
    parameter int HOLD = 5
) (
    input wire logic clk_i,
    output logic ce_n_o,
    output logic cle_o,
    output logic ale_o,
    output logic we_n_o,
    output logic re_n_o,
    output logic dqs_o,
    output logic [7:0] dq_o
);
    // order: ce_n cle ale we_n re_n dqs dq
    // start idle with the strobe high so no termination comes on
    logic [13:0] p_r = 14'h0700;
    assign {ce_n_o, cle_o, ale_o, we_n_o, re_n_o, dqs_o, dq_o} = p_r;
    // every level held several clocks so the device synchroniser sees it
    task automatic put(input logic [13:0] v);
        @(posedge clk_i);
        p_r <= v;
        repeat (HOLD) @(posedge clk_i);
    endtask
    // strobe high keeps termination off; released data lines toggle
    task automatic idle();
        put({6'h07, ~p_r[7:0]});
    endtask
    task automatic cmd(input logic [7:0] c);
        put({6'h13, c});
        put({6'h17, c});
        idle();
    endtask
    task automatic wbyte(input logic [7:0] b);
        put({6'h06, b});
        put({6'h07, b});
    endtask
endmodule // odt_host_model
`default_nettype wire

/* tb/test_odt_termination_control.sv */
// self-checking bench for the termination controller
`timescale 1ns/10ps
`default_nettype none
module test_odt_termination_control;
    import odt_pkg::*;
    typedef struct {
        logic [7:0] adr;
        logic [31:0] mask;
        logic [31:0] val;
    } note_t;
    // mask, strength, own, selected, input mode, expected code
    localparam logic [27:0] SNIFF [6] = '{28'h0C40024, 28'h0C40034, 28'h0340304, 28'h0340314,
        28'h0C4212A, 28'h0340320};
    localparam logic [7:0] KEEP [4] = '{8'hFA, 8'hFC, 8'hFF, 8'hFD};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
    logic [3:0] sel_i = 4'hF;
    logic ce_n, cle, ale, we_n, re_n, dqs;
    logic [7:0] dq;
    logic exec, addr_me, in_b, out_b;
    logic [3:0] own, sel;
    logic dq_en, re_en;
    rtt_code_t dq_code, re_code;
    note_t notes[$];
    int err_count = 0;
    int compares = 0;
    always #5 clk_i = ~clk_i;
    odt_termination_control i_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
        .ack_o, .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .dqs_i(dqs),
        .dq_i(dq), .lun_exec_i(exec), .lun_addressed_i(addr_me), .own_vol_i(own), .sel_vol_i(sel),
        .data_in_burst_i(in_b), .data_out_burst_i(out_b), .dq_odt_en_o(dq_en), .re_odt_en_o(re_en),
        .dq_rtt_o(dq_code), .re_rtt_o(re_code));
    odt_host_model #(.HOLD(5)) host (.clk_i, .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
        .re_n_o(re_n), .dqs_o(dqs), .dq_o(dq));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        notes.push_back('{a, m, v});
        bus(1'b0, a, $urandom, 4'($urandom));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s);
    endtask
    // m holds exec, input burst, output burst
    task automatic core(input logic [2:0] m, input logic [3:0] ow, input logic [3:0] sv);
        {exec, in_b, out_b} <= m;
        own <= ow;
        sel <= sv;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic cfg(input logic [31:0] c);
        addr_me <= 1'b1;
        host.cmd(8'hE2);
        for (int k = 0; k < 4; k++) host.wbyte(c[8*k +: 8]);
        // end the loading burst so its strobes leave no sniff flag behind
        host.put(14'h1700);
        host.idle();
        addr_me <= 1'b0;
        rd(8'h08, 32'hFFFFFFFF, c);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // status bits 10:3 mirror the termination ports
    always @(posedge clk_i) begin : watch
        note_t n;
        logic [7:0] p;
        if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            p = {re_code, dq_code, re_en, dq_en};
            compares++;
            if ((dat_o & n.mask) !== (n.val & n.mask)) begin
                err_count++;
                $display("mismatch reg %h expected %h seen %h", n.adr, n.val & n.mask, dat_o & n.mask);
            end
            if (n.adr == 8'h04 && (p & n.mask[10:3]) !== (n.val[10:3] & n.mask[10:3])) begin
                err_count++;
                $display("mismatch odt ports expected %h seen %h", n.val[10:3] & n.mask[10:3], p & n.mask[10:3]);
            end
        end
    end
    // about 25 times the expected run
    initial begin
        #400000;
        err_count++;
        $display("mismatch watchdog expected done seen hang");
        summarize();
    end
    initial begin
        logic [7:0] ua;
        logic [3:0] sv;
        logic [31:0] ex;
        void'($urandom(32'hF9F3));
        {exec, in_b, out_b} <= 3'h0;
        addr_me <= 1'b0;
        own <= 4'h0;
        sel <= 4'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ua = {6'($urandom_range(63, 3)), 2'h0};
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h04, 32'h7FF, 32'h0);
        wr(ua, 32'hFFFFFFFF, 4'hF);
        rd(ua, 32'hFFFFFFFF, 32'h0);
        wr(8'h00, 32'h1, 4'h0);
        rd(8'h00, 32'h1, 32'h0);
        wr(8'h04, 32'h7FF, 4'hF);
        rd(8'h04, 32'h7FF, 32'h0);
        $display("test registers done");
        core(3'h6, 4'h0, 4'h0);
        rd(8'h04, 32'h7FF, 32'h0);
        wr(8'h00, 32'h1, 4'hF);
        rd(8'h04, 32'h7FF, 32'h48);
        core(3'h2, 4'h0, 4'h0);
        rd(8'h04, 32'h7FF, 32'h0);
        core(3'h5, 4'h0, 4'h0);
        host.put(14'h0500);
        rd(8'h04, 32'h7FF, 32'h210);
        host.idle();
        core(3'h0, 4'h0, 4'h0);
        $display("test self termination done");
        cfg(32'h03020001);
        core(3'h2, 4'h0, 4'h0);
        rd(8'h04, 32'h7FF, 32'h4D);
        core(3'h5, 4'h0, 4'h0);
        rd(8'h04, 32'h7FF, 32'h315);
        core(3'h6, 4'h0, 4'h0);
        rd(8'h04, 32'h7FF, 32'h4D);
        core(3'h0, 4'h0, 4'h0);
        for (int n = 0; n < 4; n++) begin
            cfg(32'h03020000 | (32'h1 << n));
            core(3'h2, 4'(n), 4'(n));
            rd(8'h04, 32'h7FF, 32'h4D);
            sv = 4'((n + 1 + $urandom_range(2, 0)) % 4);
            core(3'h0, 4'(n), sv);
            rd(8'h04, 32'h7FF, 32'h3);
        end
        $display("test selected volume done");
        foreach (SNIFF[i]) begin
            cfg({8'h00, SNIFF[i][19:12], 8'h00, SNIFF[i][27:20]});
            core(3'h0, SNIFF[i][11:8], SNIFF[i][7:4]);
            ex = (SNIFF[i][2:0] != 3'h0) ? {24'h0, SNIFF[i][2:0], 5'h0F} : 32'h3;
            rd(8'h04, 32'hF, ex & 32'h7);
            host.put(SNIFF[i][3] ? 14'h0600 : 14'h0500);
            rd(8'h04, 32'h7FF, ex);
            host.put(14'h1700);
            rd(8'h04, 32'hF, ex & 32'h7);
            host.idle();
        end
        $display("test sniff done");
        cfg(32'h0);
        core(3'h0, 4'h1, 4'h2);
        host.put(14'h0500);
        rd(8'h04, 32'hF, 32'h3);
        host.idle();
        core(3'h6, 4'h1, 4'h1);
        rd(8'h04, 32'h1F, 32'h5);
        $display("test unconfigured done");
        cfg(32'h03020001);
        foreach (KEEP[i]) begin
            host.cmd(KEEP[i]);
            rd(8'h08, 32'hFFFFFFFF, 32'h03020001);
        end
        addr_me <= 1'b1;
        host.cmd(8'hFD);
        addr_me <= 1'b0;
        rd(8'h08, 32'hFFFFFFFF, 32'h0);
        rd(8'h04, 32'h1, 32'h1);
        $display("test reset retention done");
        // let the watcher take the last note before counting leftovers
        @(posedge clk_i);
        if (notes.size() != 0) begin
            err_count++;
            $display("mismatch notes expected 0 seen %0d", notes.size());
        end
        summarize();
    end
endmodule // test_odt_termination_control
`default_nettype wire
